// ---- hw/adc_fmt_pkg.sv ----
// Shared constants, types and register map of the converter result back end
// Operation
// - Single-ended clamps to 4095 and zero
// - Differential clamps to 2047 and -2048
// - Differential result is 16-bit sign-extended
// - Default right-adjusted, low byte holds LSBs
// - Left adjust moves MSBs to high byte
// - Sum 1 to 128 samples, powers of two
// - Widths 12 to 15 bits, zero padded by adjust
// - Two samples give 13-bit sum
// - Sixteen samples fill all 16 bits
// - Over sixteen samples drop low bits
// - Single-ended unsigned, differential two's complement
// - Differential right adjust pads with sign
// - Completed sum stored, ready flag set
package adc_fmt_pkg;
  localparam int RAW_W = 14;
  localparam int CLAMP_W = 13;
  localparam int ACC_W = 20;
  localparam int VAL_W = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int SCNT_W = 3;
  localparam int CNT_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h10;
  // Field positions
  localparam int LEFT_BIT = 0;
  localparam int DIFF_BIT = 1;
  localparam int SCNT_LSB = 0;
  localparam int START_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int RDY_BIT = 0;
  // Reset values
  localparam logic RST_LEFT = 1'h0;
  localparam logic RST_DIFF = 1'h0;
  localparam logic [SCNT_W-1:0] RST_SCNT = 3'h0;
  localparam logic [VAL_W-1:0] RST_VALUE = 16'h0000;
  // Saturation limits
  localparam logic signed [RAW_W-1:0] SE_MAX = 14'sh0FFF;
  localparam logic signed [RAW_W-1:0] SE_MIN = 14'sh0000;
  localparam logic signed [RAW_W-1:0] DF_MAX = 14'sh07FF;
  localparam logic signed [RAW_W-1:0] DF_MIN = -14'sh0800;
  // Sample-count code that fills exactly 16 bits
  localparam logic [SCNT_W-1:0] FULL_K = 3'h4;
  // Formatting latency from the go pulse to stored value, in clocks
  localparam int FMT_CYCLES = 2;

  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_FORMAT, ST_STORE} seq_state_t;
endpackage : adc_fmt_pkg

// ---- hw/fmt_if.sv ----
// Link between the sequencer and the result formatter
`timescale 1ns/1ps
interface fmt_if;
  import adc_fmt_pkg::*;
  logic go;
  logic signed [ACC_W-1:0] sum;
  logic [SCNT_W-1:0] k;
  logic left;
  logic done;
  logic [VAL_W-1:0] value;
  modport seq (output go, output sum, output k, output left, input done, input value);
  modport fmt (input go, input sum, input k, input left, output done, output value);
endinterface : fmt_if

// ---- hw/result_formatter.sv ----
// Places an accumulated sum into the 16-bit result layout
`timescale 1ns/1ps
module result_formatter (
  input wire logic clk_sys,
  input wire logic rst,
  fmt_if.fmt fi
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    logic done;
    logic [VAL_W-1:0] value;
  } fmt_state_t;

  fmt_state_t s_r, s_nxt;

  // Sum is already signed, so sign or zero padding falls out of the slice
  function automatic logic [VAL_W-1:0] place(input logic signed [ACC_W-1:0] sum,
                                             input logic [SCNT_W-1:0] k,
                                             input logic left);
    logic signed [ACC_W-1:0] shifted;
    shifted = sum;
    if (k > FULL_K) begin
      shifted = sum >>> (k - FULL_K);
    end else if (left) begin
      shifted = sum <<< (FULL_K - k);
    end
    // Right adjust keeps the slice: zeros or sign above the sum
    return shifted[VAL_W-1:0];
  endfunction : place

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (fi.go) begin
      s_nxt.value = place(fi.sum, fi.k, fi.left);
      s_nxt.done = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fi.done = s_r.done;
  assign fi.value = s_r.value;
endmodule : result_formatter

// ---- hw/adc_result_accumulate_format.sv ----
// Converter result back end: clamp, accumulate, format, Avalon-MM registers
`timescale 1ns/1ps
module adc_result_accumulate_format (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [adc_fmt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [adc_fmt_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [adc_fmt_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic conv_start,
  output logic conv_diff,
  input wire logic raw_valid,
  input wire logic signed [adc_fmt_pkg::RAW_W-1:0] raw_code,
  output logic result_ready_flag,
  output logic busy
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    seq_state_t state;
    logic left_adjust_sel;
    logic diff_sel;
    logic [SCNT_W-1:0] sample_count_sel;
    logic seq_left;
    logic seq_diff;
    logic [SCNT_W-1:0] seq_k;
    logic signed [ACC_W-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic [VAL_W-1:0] result_value;
    logic rdy;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic start;
    logic go;
  } main_state_t;

  main_state_t s_r, s_nxt;
  fmt_if fi ();

  // Saturate an over-range raw code into the legal code range
  function automatic logic signed [CLAMP_W-1:0] clamp(input logic signed [RAW_W-1:0] raw,
                                                      input logic diff);
    logic signed [RAW_W-1:0] c;
    c = raw;
    if (diff) begin
      if (raw > DF_MAX) begin
        c = DF_MAX;
      end else if (raw < DF_MIN) begin
        c = DF_MIN;
      end
    end else begin
      if (raw > SE_MAX) begin
        c = SE_MAX;
      end else if (raw < SE_MIN) begin
        c = SE_MIN;
      end
    end
    return c[CLAMP_W-1:0];
  endfunction : clamp

  // Sign-extend a clamped code to accumulator width
  function automatic logic signed [ACC_W-1:0] widen(input logic signed [CLAMP_W-1:0] c);
    return {{(ACC_W-CLAMP_W){c[CLAMP_W-1]}}, c};
  endfunction : widen

  // Read multiplexer; unmapped offsets read as zero
  function automatic logic [DATA_W-1:0] read_mux(input main_state_t s,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    d = '0;
    case (a)
      OFS_CONTROL_A: begin
        d[LEFT_BIT] = s.left_adjust_sel;
        d[DIFF_BIT] = s.diff_sel;
      end
      OFS_CONTROL_B: begin
        d[SCNT_LSB +: SCNT_W] = s.sample_count_sel;
      end
      OFS_COMMAND: begin
        d[BUSY_BIT] = (s.state != ST_IDLE);
      end
      OFS_STATUS: begin
        d[RDY_BIT] = s.rdy;
      end
      OFS_RESULT: begin
        d[VAL_W-1:0] = s.result_value;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : read_mux

  // Number of samples a sequence needs for a sample-count code
  function automatic logic [CNT_W-1:0] target(input logic [SCNT_W-1:0] k);
    return 8'h01 << k;
  endfunction : target

  logic bus_req;
  assign bus_req = avs_read | avs_write;

  // Next state: bus slave, then sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.go = 1'b0;
    s_nxt.ack = 1'b0;

    // First cycle of a request captures read data, second completes it
    if (bus_req && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = read_mux(s_r, avs_address);
    end

    // Writes act only on the edge that ends the cycle with waitrequest low
    if (avs_write && s_r.ack && avs_byteenable[0]) begin
      case (avs_address)
        OFS_CONTROL_A: begin
          s_nxt.left_adjust_sel = avs_writedata[LEFT_BIT];
          s_nxt.diff_sel = avs_writedata[DIFF_BIT];
        end
        OFS_CONTROL_B: begin
          s_nxt.sample_count_sel = avs_writedata[SCNT_LSB +: SCNT_W];
        end
        OFS_COMMAND: begin
          // A start while a sequence runs is ignored
          if (avs_writedata[START_BIT] && s_r.state == ST_IDLE) begin
            s_nxt.state = ST_REQ;
            s_nxt.acc = '0;
            s_nxt.cnt = '0;
            s_nxt.seq_left = s_r.left_adjust_sel;
            s_nxt.seq_diff = s_r.diff_sel;
            s_nxt.seq_k = s_r.sample_count_sel;
          end
        end
        OFS_STATUS: begin
          // Write one to clear; a same-cycle completion below wins
          if (avs_writedata[RDY_BIT]) begin
            s_nxt.rdy = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Sample sequencer
    case (s_r.state)
      ST_IDLE: begin
      end
      ST_REQ: begin
        s_nxt.start = 1'b1;
        s_nxt.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (raw_valid) begin
          s_nxt.acc = s_r.acc + widen(clamp(raw_code, s_r.seq_diff));
          s_nxt.cnt = s_r.cnt + 8'h01;
          if (s_r.cnt + 8'h01 == target(s_r.seq_k)) begin
            s_nxt.state = ST_FORMAT;
          end else begin
            s_nxt.state = ST_REQ;
          end
        end
      end
      ST_FORMAT: begin
        s_nxt.go = 1'b1;
        s_nxt.state = ST_STORE;
      end
      ST_STORE: begin
        if (fi.done) begin
          s_nxt.result_value = fi.value;
          s_nxt.rdy = 1'b1;
          s_nxt.state = ST_IDLE;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.left_adjust_sel <= RST_LEFT;
      s_r.diff_sel <= RST_DIFF;
      s_r.sample_count_sel <= RST_SCNT;
      s_r.result_value <= RST_VALUE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Formatter hookup; go follows the final sum by one cycle
  assign fi.go = s_r.go;
  assign fi.sum = s_r.acc;
  assign fi.k = s_r.seq_k;
  assign fi.left = s_r.seq_left;

  result_formatter u_fmt (
    .clk_sys(clk_sys),
    .rst(rst),
    .fi(fi.fmt)
  );

  // Outputs
  assign avs_waitrequest = bus_req & ~s_r.ack;
  assign avs_readdata = s_r.rdata;
  assign conv_start = s_r.start;
  assign conv_diff = s_r.seq_diff;
  assign result_ready_flag = s_r.rdy;
  assign busy = (s_r.state != ST_IDLE);
endmodule : adc_result_accumulate_format

// ---- sim/adc_fmt_asserts.sv ----
// Port-level checks for the converter result back end
`timescale 1ns/1ps
module adc_fmt_asserts
  import adc_fmt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [adc_fmt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [adc_fmt_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic conv_start,
  input wire logic conv_diff,
  input wire logic raw_valid,
  input wire logic result_ready_flag,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Bus answers after exactly one wait cycle
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  chk_start_busy: assert property (conv_start |-> busy)
    else $error("start outside sequence");
  chk_first_req: assert property ($rose(busy) |-> ##[1:2] conv_start)
    else $error("no first sample request");
  // Mode is latched for the whole sequence
  chk_diff_held: assert property (busy && $past(busy) |-> $stable(conv_diff))
    else $error("mode changed mid sequence");
  chk_ready_late: assert property ($rose(result_ready_flag) |-> $past(raw_valid, 3) || $past(raw_valid, 4))
    else $error("ready not tied to last sample");
  chk_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > OFS_RESULT |-> avs_readdata == '0)
    else $error("unmapped read not zero");
endmodule : adc_fmt_asserts

bind adc_result_accumulate_format adc_fmt_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_start(conv_start),
  .conv_diff(conv_diff), .raw_valid(raw_valid), .result_ready_flag(result_ready_flag), .busy(busy));

// ---- sim/conv_core_model.sv ----
// Behavioural analog core: one code per sample request
`timescale 1ns/1ps
module conv_core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic slow,
  input wire logic signed [adc_fmt_pkg::RAW_W-1:0] next_code,
  output logic raw_valid,
  output logic signed [adc_fmt_pkg::RAW_W-1:0] raw_code
);
  int cnt;
  // Code flips outside valid cycles so stale data never matches
  always @(posedge clk_sys or posedge rst) begin
    raw_valid <= 1'b0;
    raw_code <= ~raw_code;
    if (rst) begin
      cnt <= 0;
      raw_code <= '0;
    end else if (conv_start) begin
      cnt <= slow ? 6 : 1;
    end else if (cnt == 1) begin
      raw_valid <= 1'b1;
      raw_code <= next_code;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : conv_core_model

// ---- sim/tb.sv ----
// Self-checking bench for the converter result back end
`timescale 1ns/1ps
module tb;
  import adc_fmt_pkg::*;
  logic clk_sys, rst, avs_read, avs_write, raw_valid, slow;
  logic avs_waitrequest, conv_start, conv_diff, result_ready_flag, busy;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic signed [RAW_W-1:0] raw_code, next_code;
  int err_count, total_checks, seed, acc, nsamp, cd;
  adc_result_accumulate_format u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_start(conv_start), .conv_diff(conv_diff), .raw_valid(raw_valid), .raw_code(raw_code),
    .result_ready_flag(result_ready_flag), .busy(busy));
  conv_core_model u_core (.clk_sys(clk_sys), .rst(rst), .conv_start(conv_start), .slow(slow),
    .next_code(next_code), .raw_valid(raw_valid), .raw_code(raw_code));
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Watchdog well above the longest sweep
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
  // Fresh random code every cycle
  always @(posedge clk_sys) next_code <= RAW_W'($random(seed));
  // Reference model: clamp and sum each accepted sample
  always @(posedge clk_sys) begin
    if (conv_start === 1'b1) check(32'(conv_diff), 32'(cd));
    if (raw_valid === 1'b1 && busy === 1'b1) begin
      acc += clampc(int'(raw_code), cd);
      nsamp++;
    end
  end
  function automatic int clampc(input int c, input int d);
    int hi, lo;
    hi = d ? 2047 : 4095;
    lo = d ? -2048 : 0;
    return c > hi ? hi : (c < lo ? lo : c);
  endfunction : clampc
  // Arithmetic shift keeps the sign of differential sums
  function automatic logic [15:0] fmt(input int a, input int k, input int l);
    if (k > 4) return 16'(a >>> (k - 4));
    return 16'(l ? a << (4 - k) : a);
  endfunction : fmt
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, expv);
    end
  endtask : check
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
    output logic [31:0] rdv);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // One full sequence in a given mode, adjust and sample count
  task automatic run(input int d, input int l, input int k);
    int n;
    n = 0;
    bus(1'b1, OFS_CONTROL_A, 32'(l + 2 * d), rd);
    bus(1'b1, OFS_CONTROL_B, 32'(k), rd);
    bus(1'b1, OFS_STATUS, 32'h1, rd);
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    acc = 0;
    nsamp = 0;
    cd = d;
    slow <= 1'($random(seed));
    bus(1'b1, OFS_COMMAND, 32'h1, rd);
    // Second start lands mid-sequence and must not restart it
    bus(1'b1, OFS_COMMAND, 32'h1, rd);
    while (result_ready_flag !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) err_count++;
    check(32'(busy), 32'h0);
    check(32'(nsamp), 32'(1 << k));
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd, 32'h1);
    bus(1'b0, OFS_RESULT, 32'h0, rd);
    check(rd, {16'h0000, fmt(acc, k, l)});
  endtask : run
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // Reset, register sanity, then sweep every mode and count
  initial begin
    seed = 32'h923e;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    slow = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, OFS_RESULT, 32'h0, rd);
    check(rd, 32'(RST_VALUE));
    bus(1'b0, 5'h14, 32'h0, rd);
    check(rd, 32'h0);
    for (int d = 0; d < 2; d++) begin
      for (int l = 0; l < 2; l++) begin
        for (int k = 0; k < 8; k++) begin
          run(d, l, k);
        end
      end
    end
    summarize();
  end
endmodule : tb
